// file: hw/ufa_top.sv
`timescale 1ns/100ps
// Function
// - 8192 bits, two 4096-bit sectors
// - sector erase leaves other sector intact
// - 512 words, 9-bit address 0 to 1ff
// - each location holds one 16-bit word
// - address msb selects sector
// - reachable from fabric port and jtag
// - no path into configuration flash
// - data reg shifts msb-first or loads
// - address reg shifts or increments, wraps
// - program/erase on rising edge, busy
// - no new operation while busy
module ufa_top (
   input  wire logic CLOCK_I,
   input  wire logic RST_B_I,
   input  wire logic DATA_REG_SERIAL_IN_I,
   input  wire logic DATA_REG_CLOCK_I,
   input  wire logic DATA_REG_SHIFT_SELECT_I,
   input  wire logic ADDR_REG_SERIAL_IN_I,
   input  wire logic ADDR_REG_CLOCK_I,
   input  wire logic ADDR_REG_SHIFT_SELECT_I,
   input  wire logic PROGRAM_I,
   input  wire logic ERASE_I,
   input  wire logic JTAG_SEL_I,
   input  wire logic JTAG_WE_I,
   input  wire logic [8:0]  JTAG_ADDR_I,
   input  wire logic [15:0] JTAG_WDATA_I,
   output logic [15:0]      JTAG_RDATA_O,
   output logic      DATA_REG_SERIAL_OUT_O,
   output logic      BUSY_O
);
   logic [15:0] data_reg, data_next;
   logic [8:0]  addr_reg, addr_next;
   logic [15:0] rdata;
   logic        data_reg_clock_reg, addr_reg_clock_reg, prog_reg, erase_reg;
   logic        load_pend_reg;
   logic [11:0] cnt_reg;
   logic [8:0]  erase_idx_reg;
   ufa_pkg::ufa_state_t   state_reg;
   ufa_pkg::ufa_mem_req_t req;

   wire dr_rise    = DATA_REG_CLOCK_I & ~data_reg_clock_reg;
   wire ar_rise    = ADDR_REG_CLOCK_I & ~addr_reg_clock_reg;
   wire prog_rise  = PROGRAM_I & ~prog_reg;
   wire erase_rise = ERASE_I & ~erase_reg;
   wire idle       = (state_reg == ufa_pkg::UFA_IDLE);
   wire jtag_on    = idle & JTAG_SEL_I;
   wire erase_last = (erase_idx_reg[7:0] == 8'hff);

   // msb-first serial shift: new bit enters at lsb, msb leaves
   assign data_next = DATA_REG_SHIFT_SELECT_I
                      ? {data_reg[14:0], DATA_REG_SERIAL_IN_I}
                      : data_reg;
   assign addr_next = ADDR_REG_SHIFT_SELECT_I
                      ? {addr_reg[7:0], ADDR_REG_SERIAL_IN_I}
                      : ((addr_reg == ufa_pkg::ADDR_MAX)
                         ? ufa_pkg::ADDR_RST
                         : addr_reg + 9'h001);

   // array port: only user words exist here, nothing else mapped
   always_comb begin
      req.we    = 1'b0;
      req.addr  = addr_reg;
      req.wdata = data_reg;
      if (state_reg == ufa_pkg::UFA_PROG && cnt_reg == 12'h000) begin
         req.we = 1'b1;
      end else if (state_reg == ufa_pkg::UFA_ERASE) begin
         req.we    = 1'b1;
         // msb kept, low bits walk the one sector
         req.addr  = {addr_reg[ufa_pkg::SECTOR_BIT], erase_idx_reg[7:0]};
         req.wdata = ufa_pkg::ERASED;
      end else if (jtag_on) begin
         req.we    = JTAG_WE_I;
         req.addr  = JTAG_ADDR_I;
         req.wdata = JTAG_WDATA_I;
      end
   end

   ufa_mem u_mem (
      .clk_i   (CLOCK_I),
      .req_i   (req),
      .rdata_o (rdata)
   );

   assign BUSY_O = ~idle;
   assign DATA_REG_SERIAL_OUT_O = data_reg[15];

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         data_reg_clock_reg <= 1'b0;
         addr_reg_clock_reg <= 1'b0;
         prog_reg  <= 1'b0;
         erase_reg <= 1'b0;
      end else begin
         data_reg_clock_reg <= DATA_REG_CLOCK_I;
         addr_reg_clock_reg <= ADDR_REG_CLOCK_I;
         prog_reg  <= PROGRAM_I;
         erase_reg <= ERASE_I;
      end
   end

   // register edges are accepted only while idle; a requested load lands one cycle later, even if busy
   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         data_reg      <= ufa_pkg::DATA_RST;
         load_pend_reg <= 1'b0;
      end else if (load_pend_reg) begin
         data_reg      <= rdata;
         load_pend_reg <= 1'b0;
      end else if (dr_rise && idle && !jtag_on) begin
         data_reg      <= data_next;
         load_pend_reg <= ~DATA_REG_SHIFT_SELECT_I;
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         addr_reg <= ufa_pkg::ADDR_RST;
      end else if (ar_rise && idle && !jtag_on) begin
         addr_reg <= addr_next;
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         JTAG_RDATA_O <= ufa_pkg::DATA_RST;
      end else if (jtag_on) begin
         JTAG_RDATA_O <= rdata;
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         state_reg     <= ufa_pkg::UFA_IDLE;
         cnt_reg       <= 12'h000;
         erase_idx_reg <= 9'h000;
      end else begin
         case (state_reg)
            ufa_pkg::UFA_IDLE: begin
               erase_idx_reg <= 9'h000;
               if (prog_rise && !JTAG_SEL_I) begin
                  state_reg <= ufa_pkg::UFA_PROG;
                  cnt_reg   <= 12'(ufa_pkg::PROG_CYC - 1);
               end else if (erase_rise && !JTAG_SEL_I) begin
                  state_reg <= ufa_pkg::UFA_ERASE;
                  cnt_reg   <= 12'(ufa_pkg::ERASE_CYC - 1);
               end
            end
            ufa_pkg::UFA_PROG: begin
               if (cnt_reg == 12'h000) begin
                  state_reg <= ufa_pkg::UFA_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 12'h001;
               end
            end
            ufa_pkg::UFA_ERASE: begin
               if (!erase_last) begin
                  erase_idx_reg <= erase_idx_reg + 9'h001;
               end
               if (cnt_reg == 12'h000) begin
                  state_reg <= ufa_pkg::UFA_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 12'h001;
               end
            end
            default: state_reg <= ufa_pkg::UFA_IDLE;
         endcase
      end
   end
endmodule : ufa_top

// file: hw/ufa_pkg.sv
package ufa_pkg;
   localparam int ADDR_W        = 9;
   localparam int DATA_W        = 16;
   localparam int WORDS         = 512;
   localparam int TOTAL_BITS    = 8192;
   localparam int SECTOR_BITS   = 4096;
   localparam int SECTOR_WORDS  = 256;
   localparam int SECTOR_BIT    = 8;
   localparam logic [8:0]  ADDR_MAX   = 9'h1ff;
   localparam logic [8:0]  ADDR_RST   = 9'h000;
   localparam logic [15:0] DATA_RST   = 16'h0000;
   localparam logic [15:0] ERASED     = 16'hffff;
   // operation times, in ns, and their cycle counts at 250 MHz
   localparam int CLK_PERIOD_NS = 4;
   localparam int PROG_TIME_NS  = 1600;
   localparam int ERASE_TIME_NS = 8000;
   localparam int PROG_CYC  = (PROG_TIME_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
   localparam int ERASE_CYC = (ERASE_TIME_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
   localparam int CNT_W = 12;

   typedef enum logic [1:0] {
      UFA_IDLE  = 2'b00,
      UFA_PROG  = 2'b01,
      UFA_ERASE = 2'b10
   } ufa_state_t;

   typedef struct packed {
      logic       we;
      logic [8:0] addr;
      logic [15:0] wdata;
   } ufa_mem_req_t;
endpackage : ufa_pkg

// file: hw/ufa_mem.sv
`timescale 1ns/100ps
module ufa_mem (
   input  wire logic                  clk_i,
   input  wire ufa_pkg::ufa_mem_req_t req_i,
   output logic [15:0]                rdata_o
);
   logic [15:0] mem [0:ufa_pkg::WORDS-1];

   always_ff @(posedge clk_i) begin
      if (req_i.we) begin
         mem[req_i.addr] <= req_i.wdata;
      end
      rdata_o <= mem[req_i.addr];
   end
endmodule : ufa_mem

// file: testbench/ufa_properties.sv
`timescale 1ns/100ps
module ufa_properties (
   input wire logic CLOCK_I,
   input wire logic RST_B_I,
   input wire logic DATA_REG_CLOCK_I,
   input wire logic PROGRAM_I,
   input wire logic ERASE_I,
   input wire logic JTAG_SEL_I,
   input wire logic DATA_REG_SERIAL_OUT_O,
   input wire logic BUSY_O
);
   logic [11:0] busy_len_reg;
   logic        prog_op_reg;

   // counts busy cycles of the running operation, notes whether it programs
   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         busy_len_reg <= 12'h000;
         prog_op_reg  <= 1'b0;
      end else if (BUSY_O) begin
         if (busy_len_reg == 12'h000) begin
            prog_op_reg <= PROGRAM_I;
         end
         if (busy_len_reg != 12'hfff) begin
            busy_len_reg <= busy_len_reg + 12'h001;
         end
      end else begin
         busy_len_reg <= 12'h000;
      end
   end

   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RST_B_I);
   a_prog_starts: assert property (
      $rose(PROGRAM_I) && !BUSY_O && !JTAG_SEL_I |-> ##[1:3] BUSY_O)
      else $error("no busy");
   a_erase_starts: assert property (
      $rose(ERASE_I) && !BUSY_O && !JTAG_SEL_I |-> ##[1:3] BUSY_O)
      else $error("no busy");
   a_busy_cause: assert property (
      $rose(BUSY_O) |-> $past(PROGRAM_I | ERASE_I)) else $error("cause");
   a_busy_hold: assert property (
      $rose(BUSY_O) |-> BUSY_O[*8]) else $error("busy short");
   a_prog_len: assert property (
      $fell(BUSY_O) && prog_op_reg |-> busy_len_reg == 12'h190)
      else $error("prog length");
   a_busy_freeze: assert property (
      BUSY_O && $past(BUSY_O) |-> $stable(DATA_REG_SERIAL_OUT_O))
      else $error("out moved");
   a_out_stands: assert property (
      !DATA_REG_CLOCK_I [*4] |-> $stable(DATA_REG_SERIAL_OUT_O))
      else $error("out moved");
   a_no_retrig: assert property (
      $fell(BUSY_O) |-> ##1 !BUSY_O) else $error("retrigger");
endmodule : ufa_properties
bind ufa_top ufa_properties u_prop (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I),
   .DATA_REG_CLOCK_I(DATA_REG_CLOCK_I), .PROGRAM_I(PROGRAM_I),
   .ERASE_I(ERASE_I), .JTAG_SEL_I(JTAG_SEL_I), .BUSY_O(BUSY_O),
   .DATA_REG_SERIAL_OUT_O(DATA_REG_SERIAL_OUT_O));

// file: testbench/ufa_bridge.sv
`timescale 1ns/100ps
module ufa_bridge (
   input  wire logic  clk_i,
   input  wire logic  sout_i,
   output logic [5:0] pins_o
);
   // native 16-bit serial presentation
   initial pins_o = 6'h00;
   // c=3 data register, c=0 address register
   task automatic pulse(input int c, input logic sh, b, output logic q);
      @(negedge clk_i);
      pins_o[c]   = sh;
      pins_o[c+2] = b;
      q           = sout_i;
      @(negedge clk_i);
      pins_o[c+1] = 1'b1;
      repeat (3) @(negedge clk_i);
      pins_o[c+1] = 1'b0;
   endtask : pulse
   task automatic word(input int c, n, input logic [15:0] w,
                       output logic [15:0] r);
      logic q;
      for (int i = n - 1; i >= 0; i--) begin
         pulse(c, 1'b1, w[i], q);
         r[i] = q;
      end
   endtask : word
endmodule : ufa_bridge

// file: testbench/tb.sv
`timescale 1ns/100ps
module tb;
   logic        clk = 1'b0, rst_b = 1'b0, prog = 1'b0, ers = 1'b0;
   logic        jsel = 1'b0, jwe = 1'b0, sout, busy, q;
   logic [8:0]  ja = 9'h000, a0, a1;
   logic [15:0] jwd = 16'h0000, jrd, w0, w1, r;
   logic [5:0]  pins;
   int          n_fail = 0, checks_done = 0;
   always #2 clk = ~clk;
   ufa_top dut (.CLOCK_I(clk), .RST_B_I(rst_b),
      .DATA_REG_SERIAL_IN_I(pins[5]), .DATA_REG_CLOCK_I(pins[4]),
      .DATA_REG_SHIFT_SELECT_I(pins[3]), .ADDR_REG_SERIAL_IN_I(pins[2]),
      .ADDR_REG_CLOCK_I(pins[1]), .ADDR_REG_SHIFT_SELECT_I(pins[0]),
      .PROGRAM_I(prog), .ERASE_I(ers), .JTAG_SEL_I(jsel), .JTAG_WE_I(jwe),
      .JTAG_ADDR_I(ja), .JTAG_WDATA_I(jwd), .JTAG_RDATA_O(jrd),
      .DATA_REG_SERIAL_OUT_O(sout), .BUSY_O(busy));
   ufa_bridge bm (.clk_i(clk), .sout_i(sout), .pins_o(pins));
   task automatic chk(input string n, input logic [15:0] s, e);
      checks_done++;
      if (s !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : close_out
   task automatic jt(input logic we, input logic [8:0] a);
      @(negedge clk);
      {jsel, jwe, ja} = {1'b1, we, a};
      repeat (3) @(negedge clk);
      {jsel, jwe} = 2'b00;
   endtask : jt
   task automatic op(input logic p, input int lim);
      int i;
      @(negedge clk);
      {prog, ers} = {p, !p};
      repeat (2) @(negedge clk);
      chk("busy", {15'h0000, busy}, 16'h0001);
      if (p) ers = 1'b1;
      for (i = 0; i < lim && busy !== 1'b0; i++) @(negedge clk);
      if (i >= lim) begin n_fail++; close_out(); end
      {prog, ers} = 2'b00;
   endtask : op
   initial begin
      void'($urandom(14));
      a0 = {1'b0, 8'($urandom)};
      a1 = {1'b1, 8'($urandom)};
      w0 = 16'($urandom);
      w1 = 16'($urandom);
      repeat (3) @(negedge clk);
      rst_b = 1'b1;
      chk("idle", jrd | {14'h0000, busy, sout}, 16'h0000);
      jwd = w0; jt(1'b1, a0);
      jwd = w1; jt(1'b1, a1);
      bm.word(0, 9, {7'h00, a1}, r);
      op(1'b0, 2100);
      jt(1'b0, a0); chk("keep", jrd, w0);
      jt(1'b0, a1); chk("erase", jrd, 16'hffff);
      $display("test erase done");
      bm.word(3, 16, w0, r);
      op(1'b1, 450);
      jt(1'b0, a1); chk("prog", jrd, w0);
      $display("test program done");
      bm.word(0, 9, {7'h00, a0}, r);
      bm.pulse(3, 1'b0, 1'b0, q);
      bm.word(3, 16, ~w0, r); chk("load", r, w0);
      $display("test load done");
      jwd = w1; jt(1'b1, 9'h000);
      bm.word(0, 9, 16'h01ff, r);
      bm.pulse(0, 1'b0, 1'b0, q);
      bm.pulse(3, 1'b0, 1'b0, q);
      bm.word(3, 16, 16'h0000, r); chk("wrap", r, w1);
      $display("test wrap done");
      close_out();
   end
endmodule : tb
